// file: logic/sasm_stereo_master.sv
// Summary of operation
// - One width and word-select period serve both channels and both directions.
// - Samples move through FIFOs as bytes, most significant byte first.
// - Fewest whole bytes per sample; padding ignored on send, zero on receive.
// - Single-stream mode interleaves left then right in one FIFO.
// - Two-stream mode puts left in FIFO 0 and right in FIFO 1.
// - Two level DMA requests per direction; the second only in two-stream mode.
// - A high request means at least one more byte may move on that FIFO.
// - Disabled transmitter sends zeros; disabled receiver discards every bit.
// - Transmit and receive enable changes take effect only at a word-select frame boundary.
// - Transmit underflow is flagged, then zeros are sent until restart.
// - Receive overflow is flagged and capture stops.
// - Control register: block enable bit 2, receive bit 1, transmit bit 0.
// - Transmit status: right room bit 2, first room bit 1, underflow bit 0.
// - Receive status: right data bit 2, first data bit 1, overflow bit 0.
// - Error bits latch on their event, stay set, and clear when read.
// - Each direction has an interrupt output enabled by software.
// - Logic runs at twice the serial clock; serial clock has equal phases.
// - Word select and serial data change on the serial clock falling edge.
module sasm_stereo_master
  import sasm_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // Register bus write
  input  wire logic [SASM_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // Register bus read
  input  wire logic [SASM_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Serial link
  output logic                        sck,
  output logic                        ws,
  output logic                        sdo,
  input  wire logic                   sdi,
  // DMA requests and interrupts
  output logic                        tx_first_fifo_request,
  output logic                        tx_right_fifo_request,
  output logic                        rx_first_fifo_request,
  output logic                        rx_right_fifo_request,
  output logic                        tx_interrupt,
  output logic                        rx_interrupt
);

  localparam int CW = $clog2(FIFO_DEPTH+1);
  localparam logic [7:0] DEPTH8 = 8'(FIFO_DEPTH);

  // A whole 32-bit sample must fit, so receive admission never stalls mid-sample.
  if (FIFO_DEPTH < 4 || FIFO_DEPTH > 128) begin : g_bad_depth
    $error("FIFO_DEPTH must lie between 4 and 128.");
  end

  typedef struct packed {
    logic [5:0]  aw_addr;
    logic        aw_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_have;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [2:0]  ctrl;
    logic [31:0] cfg;
    logic        tx_err;
    logic        rx_err;
    logic        sck;
    logic        ws;
    logic        sdo;
    logic [5:0]  bitcnt;
    logic        tx_active;
    logic        tx_dead;
    logic [31:0] tx_stage;
    logic        tx_have;
    logic [2:0]  tx_got;
    logic        tx_load_right;
    logic [31:0] tx_sr;
    logic [5:0]  tx_left;
    logic        rx_active;
    logic        rx_dead;
    logic        rx_cap;
    logic        rx_right;
    logic [31:0] rx_sr;
    logic [5:0]  rx_cnt;
    logic [31:0] rx_out;
    logic [2:0]  rx_out_left;
    logic        rx_out_right;
  } sasm_state_t;

  sasm_state_t st;
  sasm_state_t next_st;

  // Index 0/1: transmit first/right, index 2/3: receive first/right.
  logic [3:0]          f_push;
  logic [3:0]          f_pop;
  logic [3:0]          f_clr;
  logic [3:0]          f_room;
  logic [3:0]          f_data;
  logic [3:0][7:0]     f_wdata;
  logic [3:0][7:0]     f_rdata;
  logic [3:0][CW-1:0]  f_level;

  logic [6:0]          period;
  logic [5:0]          half;
  logic [5:0]          width;
  logic [2:0]          nbytes;
  logic [5:0]          next_bitcnt;
  logic                next_ws;
  logic [5:0]          next_pos;
  logic [5:0]          cur_pos;
  logic                ev_under;
  logic                ev_over;
  logic [1:0]          tx_src;
  logic [1:0]          rx_dst;
  logic [1:0]          rx_unl;

  function automatic logic reg_hit(input logic [5:0] a);
    return a[5] == 1'b0 && a[1:0] == 2'h0;
  endfunction : reg_hit

  function automatic logic [5:0] slot_pos(input logic [5:0] cnt, input logic [5:0] h);
    return (cnt >= h) ? cnt - h : cnt;
  endfunction : slot_pos

  // ----------------------------------------------------------------------
  // Byte FIFOs
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_fifo
    sasm_byte_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .clear     (f_clr[i]),
      .push      (f_push[i]),
      .push_data (f_wdata[i]),
      .has_room  (f_room[i]),
      .pop       (f_pop[i]),
      .pop_data  (f_rdata[i]),
      .has_data  (f_data[i]),
      .level     (f_level[i])
    );
  end

  // ----------------------------------------------------------------------
  // Shared timing and outputs
  // ----------------------------------------------------------------------
  assign period      = sasm_period(st.cfg[SASM_CFG_PERIOD +: 2]);
  assign half        = 6'(period >> 1);
  assign width       = st.cfg[SASM_CFG_WIDTH +: 6];
  assign nbytes      = sasm_bytes(width);
  assign next_bitcnt = (st.bitcnt >= 6'(period - 7'h01)) ? 6'h00 : st.bitcnt + 6'h01;
  assign next_ws     = next_bitcnt >= half;
  assign next_pos    = slot_pos(next_bitcnt, half);
  assign cur_pos     = slot_pos(st.bitcnt, half);
  assign tx_src      = {1'b0, st.cfg[SASM_CFG_TXSPLIT] & st.tx_load_right};
  assign rx_dst      = {1'b1, st.cfg[SASM_CFG_RXSPLIT] & st.rx_right};
  assign rx_unl      = {1'b1, st.rx_out_right};

  assign s_axi_awready = !st.aw_have && !st.bvalid;
  assign s_axi_wready  = !st.w_have && !st.bvalid;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign sck           = st.sck;
  assign ws            = st.ws;
  assign sdo           = st.sdo;

  assign tx_first_fifo_request = f_room[0];
  assign tx_right_fifo_request = st.cfg[SASM_CFG_TXSPLIT] & f_room[1];
  assign rx_first_fifo_request = f_data[2];
  assign rx_right_fifo_request = st.cfg[SASM_CFG_RXSPLIT] & f_data[3];
  assign tx_interrupt          = st.tx_err & st.cfg[SASM_CFG_TXIRQ];
  assign rx_interrupt          = st.rx_err & st.cfg[SASM_CFG_RXIRQ];

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st  = st;
    f_push   = '0;
    f_pop    = '0;
    f_clr    = '0;
    f_wdata  = '0;
    ev_under = 1'b0;
    ev_over  = 1'b0;
    // Register writes: address and data may arrive in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_addr = s_axi_awaddr;
      next_st.aw_have = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
      next_st.w_have = 1'b1;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_have && st.w_have) begin
      next_st.aw_have = 1'b0;
      next_st.w_have  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = reg_hit(st.aw_addr) ? SASM_RESP_OKAY : SASM_RESP_DECERR;
      if ({st.aw_addr[5:2], 2'h0} == SASM_OFF_CTRL && st.w_strb[0]) begin
        next_st.ctrl = st.w_data[2:0];
      end
      if ({st.aw_addr[5:2], 2'h0} == SASM_OFF_CONFIG) begin
        for (int b = 0; b < 4; b++) begin
          if (st.w_strb[b]) next_st.cfg[8*b +: 8] = st.w_data[8*b +: 8] & SASM_CFG_MASK[8*b +: 8];
        end
        next_st.cfg[SASM_CFG_WIDTH +: 6] = sasm_fit_width(next_st.cfg[SASM_CFG_WIDTH +: 6],
                                                          next_st.cfg[SASM_CFG_PERIOD +: 2]);
        f_clr[1:0] = {2{st.w_strb[3] & st.w_data[SASM_CFG_TXCLR]}};
        f_clr[3:2] = {2{st.w_strb[3] & st.w_data[SASM_CFG_RXCLR]}};
      end
      for (int i = 0; i < 2; i++) begin
        if ({st.aw_addr[5:2], 2'h0} == (SASM_OFF_TXF0 + 6'(4 * i))) begin
          f_push[i]  = st.w_strb[0];
          f_wdata[i] = st.w_data[7:0];
        end
      end
    end
    // Register reads.
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = '0;
      next_st.rresp  = reg_hit(s_axi_araddr) ? SASM_RESP_OKAY : SASM_RESP_DECERR;
      case ({s_axi_araddr[5:2], 2'h0})
        SASM_OFF_CTRL:   next_st.rdata[2:0] = st.ctrl;
        SASM_OFF_TXSTAT: begin
          next_st.rdata[2:0] = {f_room[1], f_room[0], st.tx_err};
          next_st.tx_err     = 1'b0;
        end
        SASM_OFF_RXSTAT: begin
          next_st.rdata[2:0] = {f_data[3], f_data[2], st.rx_err};
          next_st.rx_err     = 1'b0;
        end
        SASM_OFF_CONFIG: next_st.rdata = st.cfg;
        SASM_OFF_RXF0:   begin
          next_st.rdata[7:0] = f_rdata[2];
          f_pop[2]           = 1'b1;
        end
        SASM_OFF_RXF1:   begin
          next_st.rdata[7:0] = f_rdata[3];
          f_pop[3]           = 1'b1;
        end
        default:         next_st.rdata = '0;
      endcase
    end
    // Transmit loader gathers the next sample ahead of its slot.
    if (!(st.ctrl[SASM_CTRL_EN] && st.ctrl[SASM_CTRL_TXEN]) && !st.tx_active) begin
      next_st.tx_have       = 1'b0;
      next_st.tx_got        = 3'h0;
      next_st.tx_load_right = 1'b0;
    end else if (!st.tx_have && f_data[tx_src]) begin
      f_pop[tx_src]    = 1'b1;
      next_st.tx_stage = {st.tx_stage[23:0], f_rdata[tx_src]};
      if (st.tx_got + 3'h1 == nbytes) begin
        next_st.tx_have       = 1'b1;
        next_st.tx_got        = 3'h0;
        next_st.tx_load_right = !st.tx_load_right;
      end else begin
        next_st.tx_got = st.tx_got + 3'h1;
      end
    end
    // Receive unloader writes a finished sample out byte by byte.
    if (st.rx_out_left != 3'h0) begin
      f_push[rx_unl]      = 1'b1;
      f_wdata[rx_unl]     = st.rx_out[31:24];
      next_st.rx_out      = st.rx_out << 8;
      next_st.rx_out_left = st.rx_out_left - 3'h1;
    end
    // Serial engine: one system cycle per serial clock phase.
    if (!st.ctrl[SASM_CTRL_EN]) begin
      next_st.sck       = 1'b0;
      next_st.ws        = 1'b0;
      next_st.sdo       = 1'b0;
      next_st.bitcnt    = 6'(period - 7'h01);
      next_st.tx_active = 1'b0;
      next_st.rx_active = 1'b0;
      next_st.tx_dead   = 1'b0;
      next_st.rx_dead   = 1'b0;
      next_st.tx_left   = 6'h00;
      next_st.rx_cnt    = 6'h00;
    end else if (st.sck) begin
      next_st.sck    = 1'b0;
      next_st.bitcnt = next_bitcnt;
      next_st.ws     = next_ws;
      if (next_bitcnt == 6'h00) begin
        next_st.tx_active = st.ctrl[SASM_CTRL_TXEN];
        next_st.rx_active = st.ctrl[SASM_CTRL_RXEN];
        if (!st.ctrl[SASM_CTRL_TXEN]) next_st.tx_dead = 1'b0;
        if (!st.ctrl[SASM_CTRL_RXEN]) next_st.rx_dead = 1'b0;
      end
      if (next_pos == 6'h01) begin
        next_st.tx_left = 6'h00;
        if (next_st.tx_active && !st.tx_dead) begin
          if (st.tx_have) begin
            next_st.tx_sr   = st.tx_stage << (6'h20 - {nbytes, 3'h0});
            next_st.tx_left = width;
            next_st.tx_have = 1'b0;
          end else begin
            ev_under        = 1'b1;
            next_st.tx_dead = 1'b1;
          end
        end
      end else if (st.tx_left != 6'h00) begin
        next_st.tx_sr   = st.tx_sr << 1;
        next_st.tx_left = st.tx_left - 6'h01;
      end
      next_st.sdo = (next_st.tx_left != 6'h00) && next_st.tx_sr[31];
    end else begin
      next_st.sck = 1'b1;
      if (cur_pos == 6'h01) begin
        next_st.rx_cap   = st.rx_active && !st.rx_dead;
        next_st.rx_right = st.ws;
        next_st.rx_sr    = {31'h0, sdi};
        next_st.rx_cnt   = 6'h01;
      end else if (st.rx_cnt != 6'h00 && st.rx_cnt < width) begin
        next_st.rx_sr  = {st.rx_sr[30:0], sdi};
        next_st.rx_cnt = st.rx_cnt + 6'h01;
        if (next_st.rx_cnt == width && st.rx_cap && !st.rx_dead) begin
          if (8'(f_level[rx_dst]) + 8'(nbytes) > DEPTH8) begin
            ev_over         = 1'b1;
            next_st.rx_dead = 1'b1;
            next_st.rx_cap  = 1'b0;
          end else begin
            next_st.rx_out       = next_st.rx_sr << (6'h20 - width);
            next_st.rx_out_left  = nbytes;
            next_st.rx_out_right = rx_dst[0];
          end
        end
      end
    end
    // A new event wins over a clearing read in the same cycle.
    if (ev_under) next_st.tx_err = 1'b1;
    if (ev_over) next_st.rx_err = 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st      <= '0;
      st.ctrl <= SASM_CTRL_RST;
      st.cfg  <= SASM_CFG_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_sck_equal_phase: assert property (
    st.ctrl[SASM_CTRL_EN] |=> (sck != $past(sck))) else $error("Serial clock did not toggle.");
  a_ws_on_fall: assert property (
    $changed(ws) && $past(st.ctrl[SASM_CTRL_EN]) |-> $fell(sck))
    else $error("Word select moved off the falling edge.");
  a_sdo_on_fall: assert property (
    $changed(sdo) && $past(st.ctrl[SASM_CTRL_EN]) |-> $fell(sck))
    else $error("Serial data moved off the falling edge.");
  a_tx_en_boundary: assert property (
    $rose(st.tx_active) |-> st.bitcnt == 6'h00 && $fell(sck) && !ws)
    else $error("Transmit enabled away from a frame boundary.");
  a_rx_en_boundary: assert property (
    $changed(st.rx_active) && $past(st.ctrl[SASM_CTRL_EN]) |-> st.bitcnt == 6'h00 && !ws)
    else $error("Receive enable changed away from a frame boundary.");
  a_under_zeros: assert property (
    st.tx_dead |-> !sdo) else $error("Data sent after transmit underflow.");
  a_under_sticky: assert property (
    ev_under |=> st.tx_err ##1 (st.tx_err || $past(s_axi_arvalid)))
    else $error("Underflow flag not latched.");
  a_over_stops: assert property (
    st.rx_dead |-> f_push[3:2] == 2'h0 && !next_st.rx_cap)
    else $error("Capture continued after receive overflow.");
  a_width_fits: assert property (
    width >= SASM_MIN_BITS && width <= half) else $error("Sample width out of range.");
  a_bvalid_hold: assert property (
    st.bvalid && !s_axi_bready |=> st.bvalid) else $error("Write response dropped.");

endmodule : sasm_stereo_master

// file: logic/sasm_pkg.sv
package sasm_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int         SASM_ADDR_W     = 6;
  localparam logic [5:0] SASM_OFF_CTRL   = 6'h00;
  localparam logic [5:0] SASM_OFF_TXSTAT = 6'h04;
  localparam logic [5:0] SASM_OFF_RXSTAT = 6'h08;
  localparam logic [5:0] SASM_OFF_CONFIG = 6'h0C;
  localparam logic [5:0] SASM_OFF_TXF0   = 6'h10;
  localparam logic [5:0] SASM_OFF_TXF1   = 6'h14;
  localparam logic [5:0] SASM_OFF_RXF0   = 6'h18;
  localparam logic [5:0] SASM_OFF_RXF1   = 6'h1C;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int          SASM_CTRL_TXEN   = 0;
  localparam int          SASM_CTRL_RXEN   = 1;
  localparam int          SASM_CTRL_EN     = 2;
  localparam int          SASM_STAT_ERR    = 0;
  localparam int          SASM_STAT_F0     = 1;
  localparam int          SASM_STAT_F1     = 2;
  localparam int          SASM_CFG_WIDTH   = 0;
  localparam int          SASM_CFG_PERIOD  = 8;
  localparam int          SASM_CFG_TXSPLIT = 12;
  localparam int          SASM_CFG_RXSPLIT = 13;
  localparam int          SASM_CFG_TXIRQ   = 16;
  localparam int          SASM_CFG_RXIRQ   = 17;
  localparam int          SASM_CFG_TXCLR   = 24;
  localparam int          SASM_CFG_RXCLR   = 25;
  localparam logic [2:0]  SASM_CTRL_RST    = 3'h0;
  localparam logic [31:0] SASM_CFG_RST     = 32'h0000_0110;
  localparam logic [31:0] SASM_CFG_MASK    = 32'h0003_333F;
  localparam logic [5:0]  SASM_MIN_BITS    = 6'h08;
  localparam logic [1:0]  SASM_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  SASM_RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [6:0] sasm_period(input logic [1:0] code);
    return 7'(({5'h00, code} + 7'h01) << 4);
  endfunction : sasm_period

  function automatic logic [2:0] sasm_bytes(input logic [5:0] bits);
    return 3'((bits + 6'h07) >> 3);
  endfunction : sasm_bytes

  function automatic logic [5:0] sasm_fit_width(input logic [5:0] bits,
                                                input logic [1:0] code);
    logic [5:0] half;
    half = 6'(sasm_period(code) >> 1);
    if (bits < SASM_MIN_BITS) return SASM_MIN_BITS;
    else if (bits > half) return half;
    else return bits;
  endfunction : sasm_fit_width

endpackage : sasm_pkg

// file: logic/sasm_byte_fifo.sv
module sasm_byte_fifo
  import sasm_pkg::*;
#(
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // Control
  input  wire logic                         clear,
  // Fill side
  input  wire logic                         push,
  input  wire logic [7:0]                   push_data,
  output logic                              has_room,
  // Drain side
  input  wire logic                         pop,
  output logic [7:0]                        pop_data,
  output logic                              has_data,
  output logic [$clog2(DEPTH+1)-1:0]        level
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least two.");
  end

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [AW-1:0]         rd;
    logic [AW-1:0]         wr;
    logic [CW-1:0]         cnt;
  } sasm_fifo_st_t;

  sasm_fifo_st_t st;
  sasm_fifo_st_t next_st;

  assign has_room = st.cnt != CW'(DEPTH);
  assign has_data = st.cnt != '0;
  assign pop_data = st.mem[st.rd];
  assign level    = st.cnt;

  always_comb begin
    next_st = st;
    if (clear) begin
      next_st.rd  = '0;
      next_st.wr  = '0;
      next_st.cnt = '0;
    end else begin
      if (push && has_room) begin
        next_st.mem[st.wr] = push_data;
        next_st.wr         = st.wr + AW'(1);
      end
      if (pop && has_data) begin
        next_st.rd = st.rd + AW'(1);
      end
      next_st.cnt = st.cnt + CW'(push && has_room) - CW'(pop && has_data);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : sasm_byte_fifo

// file: tb/sasm_codec_model.sv
module sasm_codec_model (
  // Serial link
  input  wire logic sck,
  input  wire logic ws,
  input  wire logic sdo,
  output logic      sdi
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] PAT = 16'hA5C3;
  // The first rise comes half a bit ahead of the first frame, so the count starts below zero.
  int          c       = -2;
  logic        last_ws = 1'b0;
  logic [15:0] sh      = 16'h0000;
  logic [15:0] caps[$];
  initial sdi = 1'b0;
  // Word select and data are read on the rise, where both have settled since the fall.
  always @(posedge sck) begin
    c = (ws != last_ws) ? 0 : c + 1;
    last_ws = ws;
    sh = {sh[14:0], sdo};
    if (c == 0) caps.push_back(sh);
  end
  // Slot bit 0 still carries the previous sample's LSB, so the pattern wraps.
  always @(negedge sck) begin
    sdi <= PAT[(15 - c) & 15];
  end
endmodule : sasm_codec_model

// file: tb/testbench.sv
module testbench
  import sasm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] TXB [4] = '{8'h12, 8'h34, 8'h56, 8'h78};
  localparam logic [7:0] RXB [4] = '{8'hA5, 8'hC3, 8'hA5, 8'hC3};
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata, r;
  logic [1:0]  bresp, rresp, rr;
  logic        awready, wready, bvalid, arready, rvalid, sck, ws, sdo, sdi;
  logic        txq0, txq1, rxq0, rxq1, txi, rxi;
  int          n_fail = 0, checks_done = 0;
  int          k;
  sasm_stereo_master #(.FIFO_DEPTH(4)) sasm_stereo_master_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sck(sck), .ws(ws), .sdo(sdo), .sdi(sdi), .tx_first_fifo_request(txq0),
    .tx_right_fifo_request(txq1), .rx_first_fifo_request(rxq0),
    .rx_right_fifo_request(rxq1), .tx_interrupt(txi), .rx_interrupt(rxi));
  sasm_codec_model sasm_codec_model_i (.sck(sck), .ws(ws), .sdo(sdo), .sdi(sdi));
  always #5 aclk = ~aclk;
  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Readies are sampled mid-cycle so the handshake edge is never raced.
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      {ha, hw, hb} = {awready, wready, bvalid};
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end while (!hb);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a);
    logic ha, hv;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      {ha, hv, r, rr} = {arready, rvalid, rdata, rresp};
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
    end while (!hv);
    rready <= 1'b0;
  endtask : rd
  task automatic results();
    if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  initial begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    results();
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(SASM_OFF_CONFIG);
    chk(r, SASM_CFG_RST);
    rd(SASM_OFF_CTRL);
    chk(r, 32'h0);
    rd(6'h20);
    chk({30'h0, rr}, {30'h0, SASM_RESP_DECERR});
    wr(SASM_OFF_CONFIG, 32'h0002_0110);
    for (int i = 0; i < 4; i++) wr(SASM_OFF_TXF0, {24'h0, TXB[i]});
    @(negedge aclk);
    chk({30'h0, txq0, txq1}, 32'h0);
    rd(SASM_OFF_TXSTAT);
    chk(r & 32'h3, 32'h0);
    wr(SASM_OFF_CTRL, 32'hFF);
    rd(SASM_OFF_CTRL);
    chk(r, 32'h7);
    repeat (600) @(posedge aclk);
    chk({16'h0, sasm_codec_model_i.caps[1]}, 32'h1234);
    chk({16'h0, sasm_codec_model_i.caps[2]}, 32'h5678);
    chk({16'h0, sasm_codec_model_i.caps[3]}, 32'h0);
    @(negedge aclk);
    chk({30'h0, rxi, rxq0}, 32'h3);
    rd(SASM_OFF_RXSTAT);
    chk(r, 32'h3);
    rd(SASM_OFF_RXSTAT);
    chk(r, 32'h2);
    rd(SASM_OFF_TXSTAT);
    chk(r & 32'h1, 32'h1);
    for (int i = 0; i < 4; i++) begin
      rd(SASM_OFF_RXF0);
      chk(r, {24'h0, RXB[i]});
    end
    @(negedge aclk);
    chk({30'h0, rxq0, rxi}, 32'h0);
    // Recovery keeps the serial clock running so the codec stays in step with the frames.
    wr(SASM_OFF_CTRL, 32'h4);
    repeat (70) @(posedge aclk);
    wr(SASM_OFF_CONFIG, 32'h0302_3110);
    rd(SASM_OFF_TXSTAT);
    chk(r, 32'h6);
    rd(SASM_OFF_RXSTAT);
    chk(r, 32'h0);
    for (int i = 0; i < 4; i++) wr(SASM_OFF_TXF0 + 6'(4 * (i / 2)), {24'h0, TXB[i]});
    k = sasm_codec_model_i.caps.size();
    wr(SASM_OFF_CTRL, 32'h7);
    repeat (300) @(posedge aclk);
    while (k < sasm_codec_model_i.caps.size() - 3 && sasm_codec_model_i.caps[k] == 16'h0)
      k++;
    chk({16'h0, sasm_codec_model_i.caps[k]}, 32'h1234);
    chk({16'h0, sasm_codec_model_i.caps[k + 1]}, 32'h5678);
    chk({16'h0, sasm_codec_model_i.caps[k + 2]}, 32'h0);
    @(negedge aclk);
    chk({30'h0, txq1, rxq1}, 32'h3);
    rd(SASM_OFF_RXF1);
    chk(r, {24'h0, RXB[0]});
    rd(SASM_OFF_RXF0);
    chk(r, {24'h0, RXB[0]});
    wr(SASM_OFF_CTRL, 32'h0);
    @(negedge aclk);
    chk({30'h0, sck, sdo}, 32'h0);
    results();
  end
endmodule : testbench
